// ### rtl/ctp_pkg.sv
// Shared constants and types for the cell and thermistor protector controller.
// Assumes a 200 MHz hclk and an AHB-Lite master with 32-bit single word transfers.
package ctp_pkg;
  // Clock and timing figures; cycle counts are derived from the printed times.
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned DWELL_NS = 1000;
  localparam int unsigned BIST_NS = 10000;
  localparam int unsigned SETTLE_NS = 5000;
  localparam logic [11:0] DWELL_CYC = 12'((DWELL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [11:0] BIST_CYC = 12'((BIST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [11:0] SETTLE_CYC = 12'((SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // Register byte offsets.
  localparam logic [7:0] A_CELL_LIMITS = 8'h00;
  localparam logic [7:0] A_TOP_CELL = 8'h04;
  localparam logic [7:0] A_LOW_MASK_A = 8'h08;
  localparam logic [7:0] A_LOW_MASK_B = 8'h0C;
  localparam logic [7:0] A_VOLT_CTRL = 8'h10;
  localparam logic [7:0] A_TEMP_LIMITS = 8'h14;
  localparam logic [7:0] A_BAL_HEAT = 8'h18;
  localparam logic [7:0] A_TEMP_CTRL = 8'h1C;
  localparam logic [7:0] A_PIN_SETUP = 8'h20;
  localparam logic [7:0] A_DEV_STATE = 8'h24;
  localparam logic [7:0] A_HIGH_A = 8'h28;
  localparam logic [7:0] A_HIGH_B = 8'h2C;
  localparam logic [7:0] A_LOW_A = 8'h30;
  localparam logic [7:0] A_LOW_B = 8'h34;
  localparam logic [7:0] A_HOT = 8'h38;
  localparam logic [7:0] A_COLD = 8'h3C;
  localparam logic [7:0] A_CELL_RESULT = 8'h40;
  localparam logic [7:0] A_BAL_STOP = 8'h44;
  // Field positions.
  localparam int CTRL_PICK_LSB = 2;
  localparam int CTRL_START_BIT = 8;
  localparam int COLD_LSB = 8;
  // Reset values and codes.
  localparam logic [3:0] RST_TOP_CELL = 4'hF;
  localparam logic [23:0] RST_PIN_SETUP = 24'h000000;
  localparam logic [2:0] PIN_ADC_TEMP = 3'h2;
  localparam logic [15:0] ADC_BLANK = 16'h8000;
  // Protector modes in field order 00, 01, 10, 11.
  typedef enum logic [1:0] {GM_STOP, GM_SCAN, GM_TEST, GM_LOCK} ctp_mode_e;
  typedef struct packed {logic over; logic under; logic bal;} ctp_vcmp_s;
  typedef struct packed {logic hot; logic cold; logic bal;} ctp_tcmp_s;
  typedef struct packed {logic [7:0] high; logic [7:0] low; logic [7:0] bal; logic [3:0] sel;} ctp_vdac_s;
  typedef struct packed {logic [4:0] hot; logic [2:0] cold; logic [7:0] bal; logic [7:0] hyst; logic [2:0] sel;} ctp_tdac_s;
endpackage : ctp_pkg

// ### rtl/ctp_ctrl.sv
// Digital control of the cell voltage and thermistor window-comparator protectors.
// Assumes an AHB-Lite master, comparators that settle within one channel dwell, and an ADC front end.
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - One shared high limit and one shared low limit serve all cell channels.
// - Channels up to top_cell_index are active; all lower ones too.
// - Low-check mask bits suppress undervoltage detection per channel.
// - Over high limit flags high fault; below low limit flags low fault.
// - Mode 00 stop, 01 round robin, 10 self-test, 11 single channel.
// - Voltage start captures limits, finish level, mode, top cell and masks.
// - Round robin visits all sixteen channels at fixed pace; inactive results dropped.
// - Balance finish crossing stops balancing on that channel, not a fault.
// - Single-channel mode holds comparators on volt_guard_channel_pick.
// - Self-test blanks results to 0x8000 or holds them until test plus settling.
// - Protectors keep running in sleep until stopped or shut down.
// - Running bit in device state; high and low flags in register pairs.
// - One hot limit and one cold limit apply to all active pins.
// - Pin active only when its setup selects ADC plus temperature input.
// - Ratio below hot limit flags hot; above cold limit flags cold.
// - With bias reference off, every pin flags both hot and cold.
// - Temperature modes share encodings; round robin also checks balance heat limit.
// - Temperature single-channel mode holds on temp_guard_channel_pick.
// - Temperature self-test withholds pin ADC data and detections; here tbist_run only stops detections, the ADC result path ignores it.
// - Temperature start captures limits, heat limit, hysteresis, mode and pin setup.
// - Temperature running bit; hot and cold flags; heat crossing pauses balancing.
module ctp_ctrl
  import ctp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire ctp_vcmp_s vcmp,
  input wire ctp_tcmp_s tcmp,
  input wire logic bias_ref_on,
  input wire logic adc_start,
  input wire logic adc_result_valid,
  input wire logic [15:0] adc_result,
  output ctp_vdac_s vdac,
  output ctp_tdac_s tdac,
  output logic [15:0] bal_stop,
  output logic bal_pause,
  output logic vbist_run,
  output logic tbist_run
);

  // One-hot decode of a channel number, shared by both scanners.
  function automatic logic [15:0] ch_hot(input logic [3:0] ch);
    ch_hot = 16'h0001 << ch;
  endfunction : ch_hot

  // Bus front end: reads take one wait state so read data comes from a flop.
  logic wr_q, rd_q, hreadyout_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q, rd_mux;
  wire addr_ok = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout_q <= 1'b1;
    end else begin
      wr_q <= addr_ok & hwrite;
      rd_q <= addr_ok & ~hwrite;
      if (addr_ok) addr_q <= haddr[7:0];
      hreadyout_q <= ~(addr_ok & ~hwrite);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata_q <= 32'h00000000;
    else if (rd_q) hrdata_q <= rd_mux;
  end
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;

  // Write strobes; an unmapped offset simply matches nothing.
  wire we_lim = wr_q & (addr_q == A_CELL_LIMITS);
  wire we_top = wr_q & (addr_q == A_TOP_CELL);
  wire we_mka = wr_q & (addr_q == A_LOW_MASK_A);
  wire we_mkb = wr_q & (addr_q == A_LOW_MASK_B);
  wire we_vctl = wr_q & (addr_q == A_VOLT_CTRL);
  wire we_tlim = wr_q & (addr_q == A_TEMP_LIMITS);
  wire we_heat = wr_q & (addr_q == A_BAL_HEAT);
  wire we_tctl = wr_q & (addr_q == A_TEMP_CTRL);
  wire we_pin = wr_q & (addr_q == A_PIN_SETUP);

  // Live settings; the engines only see them through the start capture.
  logic [23:0] lim_q, pin_q;
  logic [3:0] top_q;
  logic [15:0] mask_q, heat_q;
  logic [5:0] vctl_q;
  logic [4:0] tctl_q;
  logic [7:0] tlim_q;
  logic vgo_q, tgo_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lim_q <= 24'h000000;
      top_q <= RST_TOP_CELL;
      mask_q <= 16'h0000;
      vctl_q <= 6'h00;
      tlim_q <= 8'h00;
      heat_q <= 16'h0000;
      tctl_q <= 5'h00;
      pin_q <= RST_PIN_SETUP;
    end else begin
      if (we_lim) lim_q <= hwdata[23:0];
      if (we_top) top_q <= hwdata[3:0];
      if (we_mka) mask_q[7:0] <= hwdata[7:0];
      if (we_mkb) mask_q[15:8] <= hwdata[7:0];
      if (we_vctl) vctl_q <= hwdata[5:0];
      if (we_tlim) tlim_q <= {hwdata[COLD_LSB+2:COLD_LSB], hwdata[4:0]};
      if (we_heat) heat_q <= hwdata[15:0];
      if (we_tctl) tctl_q <= hwdata[4:0];
      if (we_pin) pin_q <= hwdata[23:0];
    end
  end
  // Start bits self-clear; the capture lands one cycle after the write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vgo_q <= 1'b0;
      tgo_q <= 1'b0;
    end else begin
      vgo_q <= we_vctl & hwdata[CTRL_START_BIT];
      tgo_q <= we_tctl & hwdata[CTRL_START_BIT];
    end
  end

  // Voltage engine state and captured settings.
  ctp_mode_e vmode_q, vmode_d;
  logic [3:0] vchan_q, vchan_d, vtop_q, vpick_q;
  logic [11:0] vdw_q, vdw_d, vbc_q, vbc_d, settle_q;
  logic [7:0] vhigh_q, vlow_q, vbal_q;
  logic [15:0] vmask_q, high_q, low_q, bstop_q;
  logic vbist_q;
  wire v_going = vmode_q == GM_SCAN || vmode_q == GM_LOCK;
  wire v_sample = v_going & (vdw_q == DWELL_CYC - 12'd1) & ~vgo_q;
  wire v_active = vchan_q <= vtop_q;
  wire [15:0] v_hot = ch_hot(vchan_q);
  // Detections are kept only for active channels; masked channels skip the low check.
  wire [15:0] high_set = (v_sample & v_active & vcmp.over) ? v_hot : 16'h0000;
  wire [15:0] low_set = (v_sample & v_active & vcmp.under & ~vmask_q[vchan_q]) ? v_hot : 16'h0000;
  wire [15:0] bstop_set = (v_sample & v_active & vmode_q == GM_SCAN & vcmp.bal) ? v_hot : 16'h0000;

  // Next state: scan walks all sixteen inputs whatever top_q says, so the round time never changes.
  always_comb begin
    vmode_d = vmode_q;
    vchan_d = vchan_q;
    vdw_d = v_going ? (v_sample ? 12'd0 : vdw_q + 12'd1) : 12'd0;
    vbc_d = vbc_q;
    if (vgo_q) begin
      vmode_d = ctp_mode_e'(vctl_q[1:0]);
      vchan_d = (vctl_q[1:0] == 2'b11) ? vctl_q[5:2] : 4'h0;
      vdw_d = 12'd0;
      vbc_d = BIST_CYC;
    end else if (vmode_q == GM_SCAN && v_sample) begin
      vchan_d = vchan_q + 4'h1;
    end else if (vmode_q == GM_TEST) begin
      vbc_d = vbc_q - 12'd1;
      if (vbc_q == 12'd1) vmode_d = GM_STOP;
    end
  end
  // Nothing but a start command, reset or the end of self-test leaves a running mode, so sleep does not stop it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vmode_q <= GM_STOP;
      vchan_q <= 4'h0;
      vdw_q <= 12'd0;
      vbc_q <= 12'd0;
      vbist_q <= 1'b0;
    end else begin
      vmode_q <= vmode_d;
      vchan_q <= vchan_d;
      vdw_q <= vdw_d;
      vbc_q <= vbc_d;
      vbist_q <= vmode_d == GM_TEST;
    end
  end
  // Settings are frozen at start so host edits mid-run cannot upset the scan.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {vhigh_q, vlow_q, vbal_q} <= 24'h000000;
      vtop_q <= RST_TOP_CELL;
      vmask_q <= 16'h0000;
      vpick_q <= 4'h0;
    end else if (vgo_q) begin
      {vbal_q, vlow_q, vhigh_q} <= lim_q;
      vtop_q <= top_q;
      vmask_q <= mask_q;
      vpick_q <= vctl_q[5:2];
    end
  end
  assign vdac = '{high: vhigh_q, low: vlow_q, bal: vbal_q, sel: vchan_q};
  assign vbist_run = vbist_q;

  // Temperature engine, same shape over eight pins.
  ctp_mode_e tmode_q, tmode_d;
  logic [2:0] tchan_q, tchan_d, tpick_q;
  logic [11:0] tdw_q, tdw_d, tbc_q, tbc_d;
  logic [4:0] thot_q;
  logic [2:0] tcold_q;
  logic [15:0] theat_q;
  logic [23:0] tpin_q;
  logic [7:0] hot_q, cold_q;
  logic tbist_q, tacc_q, pause_q;
  wire t_going = tmode_q == GM_SCAN || tmode_q == GM_LOCK;
  wire t_sample = t_going & (tdw_q == DWELL_CYC - 12'd1) & ~tgo_q;
  wire [2:0] t_field = tpin_q[3*tchan_q +: 3];
  wire t_active = t_field == PIN_ADC_TEMP;
  wire [15:0] t_hot16 = ch_hot({1'b0, tchan_q});
  // The comparator bits already encode the ratio test; a dead reference forces both flags.
  wire t_bad = ~bias_ref_on;
  wire [7:0] hot_set = (t_sample & (t_bad | (t_active & tcmp.hot))) ? t_hot16[7:0] : 8'h00;
  wire [7:0] cold_set = (t_sample & (t_bad | (t_active & tcmp.cold))) ? t_hot16[7:0] : 8'h00;
  wire t_heat = t_sample & tmode_q == GM_SCAN & t_active & bias_ref_on & tcmp.bal;

  always_comb begin
    tmode_d = tmode_q;
    tchan_d = tchan_q;
    tdw_d = t_going ? (t_sample ? 12'd0 : tdw_q + 12'd1) : 12'd0;
    tbc_d = tbc_q;
    if (tgo_q) begin
      tmode_d = ctp_mode_e'(tctl_q[1:0]);
      tchan_d = (tctl_q[1:0] == 2'b11) ? tctl_q[4:2] : 3'h0;
      tdw_d = 12'd0;
      tbc_d = BIST_CYC;
    end else if (tmode_q == GM_SCAN && t_sample) begin
      tchan_d = tchan_q + 3'h1;
    end else if (tmode_q == GM_TEST) begin
      tbc_d = tbc_q - 12'd1;
      if (tbc_q == 12'd1) tmode_d = GM_STOP;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmode_q <= GM_STOP;
      tchan_q <= 3'h0;
      tdw_q <= 12'd0;
      tbc_q <= 12'd0;
      tbist_q <= 1'b0;
    end else begin
      tmode_q <= tmode_d;
      tchan_q <= tchan_d;
      tdw_q <= tdw_d;
      tbc_q <= tbc_d;
      tbist_q <= tmode_d == GM_TEST;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thot_q <= 5'h00;
      tcold_q <= 3'h0;
      theat_q <= 16'h0000;
      tpin_q <= RST_PIN_SETUP;
      tpick_q <= 3'h0;
    end else if (tgo_q) begin
      {tcold_q, thot_q} <= tlim_q;
      theat_q <= heat_q;
      tpin_q <= pin_q;
      tpick_q <= tctl_q[4:2];
    end
  end
  // Pause is refreshed once per sweep, so one cool pin cannot mask a hot one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tacc_q <= 1'b0;
      pause_q <= 1'b0;
    end else if (tgo_q || tmode_q != GM_SCAN) begin
      tacc_q <= 1'b0;
      pause_q <= 1'b0;
    end else if (t_sample && tchan_q == 3'h7) begin
      tacc_q <= 1'b0;
      pause_q <= tacc_q | t_heat;
    end else begin
      tacc_q <= tacc_q | t_heat;
    end
  end
  assign tdac = '{hot: thot_q, cold: tcold_q, bal: theat_q[7:0], hyst: theat_q[15:8], sel: tchan_q};
  assign tbist_run = tbist_q;
  assign bal_pause = pause_q;

  // Fault flags are write-one-to-clear and a new detection wins over a clear.
  function automatic logic [7:0] we_f(input logic [7:0] a);
    we_f = (wr_q && addr_q == a) ? hwdata[7:0] : 8'h00;
  endfunction : we_f
  wire [15:0] high_clr = {we_f(A_HIGH_B), we_f(A_HIGH_A)};
  wire [15:0] low_clr = {we_f(A_LOW_B), we_f(A_LOW_A)};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_q <= 16'h0000;
      low_q <= 16'h0000;
      hot_q <= 8'h00;
      cold_q <= 8'h00;
      bstop_q <= 16'h0000;
    end else begin
      high_q <= (high_q & ~high_clr) | high_set;
      low_q <= (low_q & ~low_clr) | low_set;
      hot_q <= (hot_q & ~we_f(A_HOT)) | hot_set;
      cold_q <= (cold_q & ~we_f(A_COLD)) | cold_set;
      bstop_q <= vgo_q ? 16'h0000 : (bstop_q | bstop_set);
    end
  end
  assign bal_stop = bstop_q;

  // Cell result path: a start during self-test blanks, a self-test during conversion holds.
  logic [15:0] result_q;
  wire inhibit = vbist_q | (settle_q != 12'd0);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_q <= 12'd0;
      result_q <= 16'h0000;
    end else begin
      if (vbist_q && vmode_d != GM_TEST) settle_q <= SETTLE_CYC;
      else if (settle_q != 12'd0) settle_q <= settle_q - 12'd1;
      if (adc_start && inhibit) result_q <= ADC_BLANK;
      else if (adc_result_valid && !inhibit) result_q <= adc_result;
    end
  end

  // Read selection; unmapped offsets read zero.
  wire [31:0] dev_state = {28'h0000000, tbist_q, vbist_q, tmode_q != GM_STOP, vmode_q != GM_STOP};
  always_comb begin
    unique case (addr_q)
      A_CELL_LIMITS: rd_mux = {8'h00, lim_q};
      A_TOP_CELL: rd_mux = {28'h0000000, top_q};
      A_LOW_MASK_A: rd_mux = {24'h000000, mask_q[7:0]};
      A_LOW_MASK_B: rd_mux = {24'h000000, mask_q[15:8]};
      A_VOLT_CTRL: rd_mux = {26'h000000, vctl_q};
      A_TEMP_LIMITS: rd_mux = {21'h00000, tlim_q[7:5], 3'h0, tlim_q[4:0]};
      A_BAL_HEAT: rd_mux = {16'h0000, heat_q};
      A_TEMP_CTRL: rd_mux = {27'h000000, tctl_q};
      A_PIN_SETUP: rd_mux = {8'h00, pin_q};
      A_DEV_STATE: rd_mux = dev_state;
      A_HIGH_A: rd_mux = {24'h000000, high_q[7:0]};
      A_HIGH_B: rd_mux = {24'h000000, high_q[15:8]};
      A_LOW_A: rd_mux = {24'h000000, low_q[7:0]};
      A_LOW_B: rd_mux = {24'h000000, low_q[15:8]};
      A_HOT: rd_mux = {24'h000000, hot_q};
      A_COLD: rd_mux = {24'h000000, cold_q};
      A_CELL_RESULT: rd_mux = {16'h0000, result_q};
      A_BAL_STOP: rd_mux = {16'h0000, bstop_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Checks on the engines.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_read_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_bist_hold;
    vbist_q [*8];
  endsequence
  a_read_wait_state: assert property (rd_q |-> s_read_wait) else $error("read wait state wrong");
  a_start_capture: assert property (vgo_q |=> vhigh_q == $past(lim_q[7:0]) && vmask_q == $past(mask_q))
    else $error("voltage settings not captured");
  a_high_flag_set: assert property (v_sample && v_active && vcmp.over |=> high_q[$past(vchan_q)])
    else $error("high fault not flagged");
  a_low_mask_block: assert property (v_sample && vmask_q[vchan_q] |-> low_set == 16'h0000)
    else $error("masked low check flagged");
  a_inactive_drop: assert property (v_sample && !v_active |-> high_set == 16'h0000 && low_set == 16'h0000)
    else $error("inactive channel flagged");
  a_scan_step: assert property (vmode_q == GM_SCAN && v_sample |=> vchan_q == $past(vchan_q) + 4'h1)
    else $error("scan did not advance");
  a_lock_hold: assert property (vmode_q == GM_LOCK && !vgo_q |=> vchan_q == vpick_q)
    else $error("lock channel moved");
  a_bist_length: assert property ($rose(vbist_q) |-> s_bist_hold) else $error("self-test ended early");
  a_result_blank: assert property (adc_start && inhibit |=> result_q == ADC_BLANK)
    else $error("result not blanked");
  a_ref_off_flags: assert property (t_sample && !bias_ref_on |=> hot_q[$past(tchan_q)] && cold_q[$past(tchan_q)])
    else $error("dead reference not flagged");
  a_flag_sticky: assert property (high_q[0] && !high_clr[0] |=> high_q[0]) else $error("flag lost");
  a_tlock_hold: assert property (tmode_q == GM_LOCK && !tgo_q |=> tchan_q == tpick_q)
    else $error("temperature lock channel moved");
  a_result_hold: assert property (vbist_q && !adc_start |=> result_q == $past(result_q))
    else $error("result changed during self-test");

endmodule : ctp_ctrl

// ### bench/test_ctp_ctrl.sv
// Self-checking bench for the protector controller: AHB-Lite register tasks and scenario sequences.
// Assumes the design answers writes with no wait and reads after one wait cycle; the bench is the only master.
`timescale 1ns/1ps
module test_ctp_ctrl
  import ctp_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, bias_ref_on, adc_start, adc_result_valid;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] adc_result, bal_stop;
  logic bal_pause, vbist_run, tbist_run;
  ctp_vcmp_s vcmp;
  ctp_tcmp_s tcmp;
  ctp_vdac_s vdac;
  ctp_tdac_s tdac;
  int n_mismatch, compares, k;
  logic [3:0] s;

  // The single slave's hreadyout is the bus's hready.
  ctp_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .vcmp(vcmp), .tcmp(tcmp), .bias_ref_on(bias_ref_on), .adc_start(adc_start),
    .adc_result_valid(adc_result_valid), .adc_result(adc_result), .vdac(vdac), .tdac(tdac),
    .bal_stop(bal_stop), .bal_pause(bal_pause), .vbist_run(vbist_run), .tbist_run(tbist_run));

  // Clock at 200 MHz.
  always #2.5 hclk = ~hclk;

  // A hang must still end in a verdict, so the watchdog is sized well past the planned run.
  initial begin
    repeat (90000) @(posedge hclk);
    n_mismatch++;
    final_report();
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Waits for hready at a rising edge; values are seen as they stood before the edge.
  task automatic wait_ready();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50) check("hready wait", 0, 1);
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rc(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    check(name, rd, exp);
  endtask : rc

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // One-cycle conversion result from the ADC front end.
  task automatic adc_put(input logic [15:0] v);
    adc_result_valid <= 1'b1;
    adc_result <= v;
    cyc(1);
    adc_result_valid <= 1'b0;
  endtask : adc_put

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  // Main sequence: each test is a run of bus calls and port checks with worked-out expectations.
  initial begin
    hclk = 0;
    hresetn = 0;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hwdata = 0;
    bias_ref_on = 1;
    adc_start = 0;
    adc_result_valid = 0;
    adc_result = 0;
    vcmp = '0;
    tcmp = '0;
    n_mismatch = 0;
    compares = 0;
    cyc(12);
    hresetn <= 1'b1;
    rc("top cell reset", A_TOP_CELL, 32'h0000000F);
    rc("pin setup reset", A_PIN_SETUP, 32'h00000000);
    rc("state reset", A_DEV_STATE, 32'h00000000);
    wr(8'h80, 32'hFFFFFFFF);
    rc("unmapped", 8'h80, 32'h00000000);
    $display("test reset and map done");
    // Voltage guard: capture on start only, fixed scan pace over all sixteen channels.
    wr(A_CELL_LIMITS, 32'h00302010);
    wr(A_TOP_CELL, 32'h00000003);
    wr(A_LOW_MASK_A, 32'h00000002);
    wr(A_VOLT_CTRL, 32'h00000101);
    cyc(4);
    check("vdac high", {24'h0, vdac.high}, 32'h10);
    check("vdac low", {24'h0, vdac.low}, 32'h20);
    check("vdac bal", {24'h0, vdac.bal}, 32'h30);
    wr(A_CELL_LIMITS, 32'h00999999);
    cyc(4);
    check("vdac held", {24'h0, vdac.high}, 32'h10);
    rc("ctrl start self clears", A_VOLT_CTRL, 32'h00000001);
    rc("volt active", A_DEV_STATE, 32'h00000001);
    k = 0;
    while (vdac.sel !== 4'hF && k < 3500) begin
      @(posedge hclk);
      k++;
    end
    check("scan reaches ch15", {28'h0, vdac.sel}, 32'hF);
    s = vdac.sel;
    k = 0;
    while (vdac.sel === s && k < 400) begin
      @(posedge hclk);
      k++;
    end
    s = vdac.sel;
    k = 0;
    while (vdac.sel === s && k < 400) begin
      @(posedge hclk);
      k++;
    end
    check("dwell cycles", k, {20'h0, DWELL_CYC});
    $display("test volt capture and scan done");
    // Faults on inactive channels and low faults on masked channels are dropped; flags stick until cleared.
    vcmp <= '{over: 1'b1, under: 1'b1, bal: 1'b0};
    cyc(3500);
    vcmp <= '0;
    cyc(3300);
    rc("high a", A_HIGH_A, 32'h0000000F);
    rc("high b", A_HIGH_B, 32'h00000000);
    rc("low a", A_LOW_A, 32'h0000000D);
    rc("low b", A_LOW_B, 32'h00000000);
    wr(A_HIGH_A, 32'h000000FF);
    wr(A_LOW_A, 32'h000000FF);
    rc("high a cleared", A_HIGH_A, 32'h00000000);
    rc("low a cleared", A_LOW_A, 32'h00000000);
    vcmp <= '{over: 1'b0, under: 1'b0, bal: 1'b1};
    cyc(3500);
    check("bal stop", {16'h0, bal_stop}, 32'h0000000F);
    rc("bal stop reg", A_BAL_STOP, 32'h0000000F);
    rc("bal not fault", A_LOW_A, 32'h00000000);
    vcmp <= '0;
    $display("test volt faults done");
    // Single channel lock, stop, then self-test with the ADC started during the test.
    wr(A_VOLT_CTRL, 32'h00000117);
    cyc(500);
    check("vdac lock", {28'h0, vdac.sel}, 32'h5);
    wr(A_VOLT_CTRL, 32'h00000100);
    cyc(4);
    rc("volt stopped", A_DEV_STATE, 32'h00000000);
    adc_put(16'h1234);
    rc("cell result taken", A_CELL_RESULT, 32'h00001234);
    wr(A_VOLT_CTRL, 32'h00000102);
    cyc(4);
    check("vbist run", {31'h0, vbist_run}, 32'h1);
    rc("state vbist", A_DEV_STATE, 32'h00000005);
    adc_put(16'h5678);
    rc("cell result held", A_CELL_RESULT, 32'h00001234);
    adc_start <= 1'b1;
    cyc(1);
    adc_start <= 1'b0;
    adc_put(16'h1234);
    rc("cell result blank", A_CELL_RESULT, {16'h0, ADC_BLANK});
    k = 0;
    while (vbist_run === 1'b1 && k < 2500) begin
      @(posedge hclk);
      k++;
    end
    check("vbist ends", {31'h0, vbist_run}, 32'h0);
    adc_put(16'h9ABC);
    rc("cell result settling", A_CELL_RESULT, {16'h0, ADC_BLANK});
    cyc(1000);
    adc_put(16'h9ABC);
    rc("cell result resumes", A_CELL_RESULT, 32'h00009ABC);
    $display("test volt modes done");
    // Temperature guard: reference off flags everything, then only the configured pin counts.
    wr(A_PIN_SETUP, {29'h0, PIN_ADC_TEMP});
    wr(A_TEMP_LIMITS, 32'h00000515);
    wr(A_BAL_HEAT, 32'h00000740);
    bias_ref_on <= 1'b0;
    wr(A_TEMP_CTRL, 32'h00000101);
    cyc(4);
    check("tdac hot", {27'h0, tdac.hot}, 32'h15);
    check("tdac cold", {29'h0, tdac.cold}, 32'h5);
    check("tdac heat", {16'h0, tdac.bal, tdac.hyst}, 32'h4007);
    rc("temp active", A_DEV_STATE, 32'h00000002);
    cyc(1900);
    rc("hot ref off", A_HOT, 32'h000000FF);
    rc("cold ref off", A_COLD, 32'h000000FF);
    bias_ref_on <= 1'b1;
    tcmp <= '{hot: 1'b1, cold: 1'b0, bal: 1'b1};
    cyc(1900);
    wr(A_HOT, 32'h000000FF);
    wr(A_COLD, 32'h000000FF);
    cyc(3500);
    rc("hot pin0", A_HOT, 32'h00000001);
    rc("cold none", A_COLD, 32'h00000000);
    check("bal pause", {31'h0, bal_pause}, 32'h1);
    tcmp <= '{hot: 1'b0, cold: 1'b1, bal: 1'b0};
    wr(A_HOT, 32'h000000FF);
    cyc(1900);
    rc("cold pin0", A_COLD, 32'h00000001);
    tcmp <= '0;
    $display("test temp scan done");
    wr(A_TEMP_CTRL, 32'h0000011B);
    cyc(500);
    check("tdac lock", {29'h0, tdac.sel}, 32'h6);
    wr(A_TEMP_CTRL, 32'h00000102);
    cyc(4);
    check("tbist run", {31'h0, tbist_run}, 32'h1);
    rc("state tbist", A_DEV_STATE, 32'h0000000A);
    $display("test temp modes done");
    final_report();
  end
endmodule : test_ctp_ctrl
